/* File: pkg/bceh_pkg.sv */
// Constants, types and the command table of the bus command error handler.
// Assumes one 20 MHz system clock; characters arrive as ASCII bytes.
package bceh_pkg;
    // Clock and message timing
    localparam int CLK_HZ          = 20_000_000;             // Core clock rate
    localparam int MS_PER_S        = 1000;                   // Milliseconds per second
    localparam int MSG_TIME_MS     = 1000;                   // Error message hold time
    localparam int MSG_CYCLES_DFLT = CLK_HZ / MS_PER_S * MSG_TIME_MS; // Hold time in cycles

    // Characters of interest
    localparam logic [7:0] CH_TERM  = 8'h58;                 // Execute terminator
    localparam logic [7:0] CH_SPACE = 8'h20;                 // Ignored filler
    localparam logic [7:0] CH_DOT   = 8'h2E;                 // Start of fraction
    localparam logic [7:0] CH_0     = 8'h30;                 // First digit
    localparam logic [7:0] CH_9     = 8'h39;                 // Last digit
    localparam logic [7:0] CH_A     = 8'h41;                 // First letter
    localparam logic [7:0] CH_Z     = 8'h5A;                 // Last letter

    // Buffered command entry layout
    localparam int LETTER_W = 5;                             // Letter index width
    localparam int OPT_W    = 8;                             // Option value width
    localparam int ENTRY_W  = LETTER_W + OPT_W;              // Stored entry width
    localparam int ACC_W    = 12;                            // Decimal accumulator width
    localparam logic [ACC_W-1:0]   DEC_BASE = 12'h00A;       // Decimal radix
    localparam logic [OPT_W-1:0]   OPT_NONE = 8'hFF;         // Letter not in command set
    localparam logic [LETTER_W-1:0] IDX_K   = 5'h0A;         // EOI and hold-off command

    // Hold-off command option bits, cleared means enabled
    localparam int K_EOI_BIT  = 0;                           // Set: no EOI
    localparam int K_HOLD_BIT = 1;                           // Set: no hold-off

    // Error status bit positions
    localparam int ERR_W         = 3;                        // Number of error bits
    localparam int ERR_IDX_CMD   = 0;                        // Illegal command letter
    localparam int ERR_IDX_OPT   = 1;                        // Illegal option
    localparam int ERR_IDX_NOREM = 2;                        // Not in remote

    // Front panel message codes
    typedef enum logic [1:0] {
        DISP_NORMAL    = 2'h0,
        DISP_ILL_CMD   = 2'h1,
        DISP_ILL_OPT   = 2'h2,
        DISP_NO_REMOTE = 2'h3
    } bceh_disp_t;

    // Parser states, one-hot
    typedef enum logic [2:0] {
        ST_COLLECT = 3'h1,
        ST_DISCARD = 3'h2,
        ST_APPLY   = 3'h4
    } bceh_state_t;

    // Highest option of each letter, OPT_NONE when the letter is undefined
    function automatic logic [OPT_W-1:0] opt_limit(input logic [LETTER_W-1:0] idx);
        case (idx)
            5'h03:   opt_limit = 8'h05;                      // D
            5'h05:   opt_limit = 8'h01;                      // F
            5'h09:   opt_limit = 8'h00;                      // J
            5'h0A:   opt_limit = 8'h03;                      // K
            5'h0C:   opt_limit = 8'h1F;                      // M
            5'h0F:   opt_limit = 8'h01;                      // P
            5'h11:   opt_limit = 8'h08;                      // R
            5'h13:   opt_limit = 8'h07;                      // T
            5'h14:   opt_limit = 8'h09;                      // U
            default: opt_limit = OPT_NONE;
        endcase
    endfunction
endpackage

/* File: pkg/bceh_mem_if.sv */
// Port bundle between the parser and its command buffer.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface bceh_mem_if #(parameter int AW = 4, parameter int DW = 13);
    logic          we;      // Write strobe
    logic [AW-1:0] waddr;   // Write address
    logic [DW-1:0] wdata;   // Write data
    logic          re;      // Read strobe
    logic [AW-1:0] raddr;   // Read address
    logic [DW-1:0] rdata;   // Registered read data
    modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
    modport mem  (input we, waddr, wdata, re, raddr, output rdata);
endinterface
`default_nettype wire

/* File: core/bceh_cmd_mem.sv */
// Small buffer holding the checked commands of one string.
// Assumes the controller never reads and writes the same entry in one cycle.
`timescale 1ns/1ns
`default_nettype none
module bceh_cmd_mem #(
    parameter int DEPTH = 16
) (
    input  wire logic core_clk,
    bceh_mem_if.mem   port
);
    logic [$bits(port.wdata)-1:0] store [DEPTH];   // Entry array

    // Write port
    always_ff @(posedge core_clk) begin
        if (port.we) begin
            store[port.waddr] <= port.wdata;
        end
    end

    // Registered read port
    always_ff @(posedge core_clk) begin
        if (port.re) begin
            port.rdata <= store[port.raddr];
        end
    end
endmodule
`default_nettype wire

/* File: core/bceh_top.sv */
// Command string parser with error handling for the bus listener port.
// Assumes bytes are presented one per rx_valid pulse, synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none
module bceh_top #(
    parameter int DEPTH      = 16,                           // Commands per string
    parameter int MSG_CYCLES = bceh_pkg::MSG_CYCLES_DFLT     // Message hold cycles
) (
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       rx_valid,
    input  wire logic [7:0]                 rx_data,
    input  wire logic                       remote_mode,
    input  wire logic                       dev_clear,
    input  wire logic                       spoll_read,
    input  wire logic [bceh_pkg::ERR_W-1:0] srq_mask,
    output logic [bceh_pkg::ERR_W-1:0]      err_status,
    output logic                            srq,
    output bceh_pkg::bceh_disp_t            disp_msg,
    output logic                            cmd_valid,
    output logic [7:0]                      cmd_letter,
    output logic [7:0]                      cmd_option,
    output logic                            nrfd_hold,
    output logic                            eoi_enable,
    output logic                            busy
);
    import bceh_pkg::*;

    localparam int AW = $clog2(DEPTH);                       // Buffer address width
    localparam int TW = $clog2(MSG_CYCLES + 1);              // Message timer width

    // Refuse sizes the logic cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 2");
    end
    if (MSG_CYCLES < 1) begin : g_bad_msg
        $error("MSG_CYCLES must be at least 1");
    end

    bceh_mem_if #(.AW(AW), .DW(ENTRY_W)) mem_bus ();         // Buffer port bundle

    bceh_cmd_mem #(.DEPTH(DEPTH)) bceh_cmd_mem_i (
        .core_clk (core_clk),
        .port     (mem_bus.mem)
    );

    bceh_state_t         state;         // Parser state
    logic                have_letter;   // A command letter is pending
    logic [LETTER_W-1:0] cur_idx;       // Pending letter index
    logic [OPT_W-1:0]    cur_opt;       // Pending option value
    logic                opt_ovf;       // Option exceeded its width
    logic                in_frac;       // Skipping fractional digits
    logic [AW:0]         wr_cnt;        // Entries written this string
    logic [AW:0]         apply_total;   // Entries to apply
    logic [AW:0]         rd_ptr;        // Next entry to read
    logic                rd_pend;       // Read data arrives this cycle
    logic                holdoff_en;    // Bus hold-off enabled
    logic [TW-1:0]       msg_timer;     // Remaining message cycles
    logic                err_evt;       // Error detected this cycle
    bceh_disp_t          err_code;      // Kind of that error
    logic                do_write;      // Store finished command
    logic                term_ok;       // Clean string terminated
    logic                fin_bad;       // Pending command is invalid
    logic                is_letter;     // Byte is a letter
    logic                is_digit;      // Byte is a digit
    logic [7:0]          letter_off;    // Byte minus first letter
    logic [ACC_W-1:0]    acc;           // Next decimal value
    logic [ERR_W-1:0]    err_set;       // Status bits to set

    // Character classes and decimal accumulation
    assign is_letter  = (rx_data >= CH_A) && (rx_data <= CH_Z);
    assign is_digit   = (rx_data >= CH_0) && (rx_data <= CH_9);
    assign letter_off = rx_data - CH_A;
    assign acc        = {4'h0, cur_opt} * DEC_BASE + {4'h0, rx_data - CH_0};
    assign fin_bad    = have_letter
                        && (opt_ovf || cur_opt > opt_limit(cur_idx) || wr_cnt[AW]);

    // Classify each byte taken while collecting
    always_comb begin
        err_evt  = 1'b0;
        err_code = DISP_NORMAL;
        do_write = 1'b0;
        term_ok  = 1'b0;
        if (state == ST_COLLECT && rx_valid) begin
            if (!remote_mode) begin
                err_evt  = 1'b1;
                err_code = DISP_NO_REMOTE;
            end else if (rx_data == CH_SPACE) begin
                err_evt  = 1'b0;
            end else if (rx_data == CH_TERM || is_letter) begin
                if (fin_bad) begin
                    err_evt  = 1'b1;
                    err_code = DISP_ILL_OPT;
                end else if (rx_data != CH_TERM
                             && opt_limit(letter_off[LETTER_W-1:0]) == OPT_NONE) begin
                    err_evt  = 1'b1;
                    err_code = DISP_ILL_CMD;
                end else begin
                    do_write = have_letter;
                    term_ok  = (rx_data == CH_TERM) && (have_letter || wr_cnt != '0);
                end
            end else if (is_digit || rx_data == CH_DOT) begin
                if (!have_letter) begin
                    err_evt  = 1'b1;
                    err_code = DISP_ILL_CMD;
                end
            end else begin
                err_evt  = 1'b1;
                err_code = DISP_ILL_CMD;
            end
        end
    end

    // Buffer port: store during parse, replay during apply
    assign mem_bus.we    = do_write;
    assign mem_bus.waddr = wr_cnt[AW-1:0];
    assign mem_bus.wdata = {cur_idx, cur_opt};
    assign mem_bus.re    = (state == ST_APPLY) && (rd_ptr != apply_total);
    assign mem_bus.raddr = rd_ptr[AW-1:0];

    // Parser state sequence
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_COLLECT;
        end else begin
            unique case (state)
                ST_COLLECT: begin
                    if (err_evt && rx_data != CH_TERM) begin
                        state <= ST_DISCARD;
                    end else if (term_ok) begin
                        state <= ST_APPLY;
                    end
                end
                ST_DISCARD: begin
                    if (rx_valid && rx_data == CH_TERM) begin
                        state <= ST_COLLECT;
                    end
                end
                ST_APPLY: begin
                    if (rd_ptr == apply_total && !rd_pend) begin
                        state <= ST_COLLECT;
                    end
                end
            endcase
        end
    end

    // Pending command and write count
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            have_letter <= 1'b0;
            cur_idx     <= '0;
            cur_opt     <= '0;
            opt_ovf     <= 1'b0;
            in_frac     <= 1'b0;
            wr_cnt      <= '0;
        end else if (err_evt || state == ST_DISCARD) begin
            have_letter <= 1'b0;
            wr_cnt      <= '0;
        end else if (state == ST_APPLY) begin
            wr_cnt      <= '0;
        end else if (state == ST_COLLECT && rx_valid) begin
            if (do_write) begin
                wr_cnt <= wr_cnt + {{AW{1'b0}}, 1'b1};
            end
            if (rx_data == CH_TERM) begin
                have_letter <= 1'b0;
            end else if (is_letter) begin
                have_letter <= 1'b1;
                cur_idx     <= letter_off[LETTER_W-1:0];
                cur_opt     <= '0;
                opt_ovf     <= 1'b0;
                in_frac     <= 1'b0;
            end else if (rx_data == CH_DOT) begin
                in_frac <= 1'b1;
            end else if (is_digit && !in_frac) begin
                cur_opt <= acc[OPT_W-1:0];
                opt_ovf <= opt_ovf | (|acc[ACC_W-1:OPT_W]);
            end
        end
    end

    // Replay of checked commands
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            apply_total <= '0;
            rd_ptr      <= '0;
            rd_pend     <= 1'b0;
            cmd_valid   <= 1'b0;
            cmd_letter  <= '0;
            cmd_option  <= '0;
        end else begin
            if (term_ok) begin
                apply_total <= wr_cnt + {{AW{1'b0}}, do_write};
                rd_ptr      <= '0;
            end else if (mem_bus.re) begin
                rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
            end
            rd_pend    <= mem_bus.re;
            cmd_valid  <= rd_pend;
            cmd_letter <= CH_A + {3'h0, mem_bus.rdata[ENTRY_W-1:OPT_W]};
            cmd_option <= mem_bus.rdata[OPT_W-1:0];
        end
    end

    // Hold-off and EOI mode, default after reset or device clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            holdoff_en <= 1'b1;
            eoi_enable <= 1'b1;
        end else if (dev_clear) begin
            holdoff_en <= 1'b1;
            eoi_enable <= 1'b1;
        end else if (rd_pend && mem_bus.rdata[ENTRY_W-1:OPT_W] == IDX_K) begin
            holdoff_en <= !mem_bus.rdata[K_HOLD_BIT];
            eoi_enable <= !mem_bus.rdata[K_EOI_BIT];
        end
    end

    // Not-ready hold and busy indication
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nrfd_hold <= 1'b0;
            busy      <= 1'b0;
        end else begin
            if (term_ok) begin
                nrfd_hold <= holdoff_en;
            end else if (state == ST_APPLY && rd_ptr == apply_total && !rd_pend) begin
                nrfd_hold <= 1'b0;
            end
            busy <= term_ok || (state == ST_APPLY && !(rd_ptr == apply_total && !rd_pend));
        end
    end

    // Sticky error bits; a new error beats a serial-poll clear
    always_comb begin
        err_set = '0;
        if (err_evt) begin
            unique case (err_code)
                DISP_ILL_CMD:   err_set[ERR_IDX_CMD]   = 1'b1;
                DISP_ILL_OPT:   err_set[ERR_IDX_OPT]   = 1'b1;
                DISP_NO_REMOTE: err_set[ERR_IDX_NOREM] = 1'b1;
                DISP_NORMAL:    err_set = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_status <= '0;
            srq        <= 1'b0;
        end else begin
            err_status <= (spoll_read ? '0 : err_status) | err_set;
            srq        <= |(((spoll_read ? '0 : err_status) | err_set) & srq_mask);
        end
    end

    // Front panel message and its hold timer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            msg_timer <= '0;
            disp_msg  <= DISP_NORMAL;
        end else if (err_evt) begin
            msg_timer <= TW'(MSG_CYCLES);
            disp_msg  <= err_code;
        end else if (msg_timer > TW'(1)) begin
            msg_timer <= msg_timer - TW'(1);
        end else begin
            msg_timer <= '0;
            disp_msg  <= DISP_NORMAL;
        end
    end

    // Checks
    sequence seq_term_ok;
        term_ok;
    endsequence
    sequence seq_err(int bitpos);
        err_evt && err_set[bitpos];
    endsequence

    AST_ERR_BIT: assert property (@(posedge core_clk) disable iff (sys_rst)
        err_evt |=> (err_status & $past(err_set)) == $past(err_set))
        else $error("error bit not set");
    AST_NO_REMOTE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_COLLECT && rx_valid && !remote_mode) |=> err_status[ERR_IDX_NOREM])
        else $error("no-remote error missed");
    AST_ILL_CMD: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_COLLECT && rx_valid && remote_mode && rx_data == 8'h40)
        |=> err_status[ERR_IDX_CMD])
        else $error("illegal letter not flagged");
    AST_DISCARD: assert property (@(posedge core_clk) disable iff (sys_rst)
        seq_err(ERR_IDX_OPT) |=> !cmd_valid [*3])
        else $error("command applied after error");
    AST_SRQ: assert property (@(posedge core_clk) disable iff (sys_rst)
        srq |-> |(err_status & $past(srq_mask)))
        else $error("service request without enabled error");
    AST_MSG_SHOW: assert property (@(posedge core_clk) disable iff (sys_rst)
        err_evt |=> disp_msg == $past(err_code) && disp_msg != DISP_NORMAL)
        else $error("wrong panel message");
    AST_MSG_END: assert property (@(posedge core_clk) disable iff (sys_rst)
        (msg_timer == TW'(1) && !err_evt) |=> disp_msg == DISP_NORMAL && msg_timer == '0)
        else $error("message not restored");
    AST_HOLDOFF: assert property (@(posedge core_clk) disable iff (sys_rst)
        (seq_term_ok and holdoff_en) |=> nrfd_hold && state == ST_APPLY)
        else $error("hold-off not asserted");
    AST_SKIP_END: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_DISCARD && rx_valid && rx_data == CH_TERM) |=> state == ST_COLLECT)
        else $error("discard did not end at terminator");
    AST_APPLY_LATE: assert property (@(posedge core_clk) disable iff (sys_rst)
        cmd_valid |-> $past(state == ST_APPLY, 2))
        else $error("command applied before string checked");
endmodule
`default_nettype wire

/* File: testbench/bceh_ctrl_model.sv */
// Bus controller model that sends command strings one byte per cycle.
// Assumes the bench waits for busy to fall before the next string.
`timescale 1ns/1ns
`default_nettype none
module bceh_ctrl_model (
    input  wire logic core_clk,
    output logic      rx_valid,
    output logic [7:0] rx_data
);
    // Idle lines: no byte, data not held
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
    end

    // Send every byte of a string, terminator included
    task automatic send(input string s);
        byte c;
        for (int k = 0; k < s.len(); k++) begin
            c = s[k];
            @(posedge core_clk);
            rx_valid <= 1'b1;
            rx_data  <= c;
        end
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_data  <= ~c; // Released data shows no stale byte
    endtask
endmodule
`default_nettype wire

/* File: testbench/bceh_top_tb_top.sv */
// Self-checking bench for the command parser and its error handling.
// Sends one string with remote cleared to check the not-in-remote error; all others with remote set.
`timescale 1ns/1ns
`default_nettype none
module bceh_top_tb_top;
    import bceh_pkg::*;
    typedef struct {
        string s; logic rem; logic [2:0] mask; logic [2:0] err;
        logic [1:0] disp; int ncmd; logic [7:0] ltr; logic [7:0] opt;
    } bceh_row_t;
    logic core_clk = 1'b0, sys_rst = 1'b1, remote_mode = 1'b1, dev_clear = 1'b0;
    logic spoll_read = 1'b0, rx_valid, srq, cmd_valid, nrfd_hold, eoi_enable, busy;
    logic [7:0] rx_data, cmd_letter, cmd_option;
    logic [2:0] srq_mask = 3'h0, err_status;
    bceh_disp_t disp_msg;
    int n_fail = 0, comparisons = 0, ncmd;
    logic [7:0] last_let, last_opt;
    logic nrfd_seen;
    bceh_row_t rows [9];
    `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
        $display("BAD %0t got %0h exp %0h", $time, a, b); end end

    // Clock of 50 ns
    always #25 core_clk = ~core_clk;

    bceh_ctrl_model bceh_ctrl_model_i (.core_clk(core_clk), .rx_valid(rx_valid),
        .rx_data(rx_data));
    bceh_top #(.DEPTH(16), .MSG_CYCLES(20)) bceh_top_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data),
        .remote_mode(remote_mode), .dev_clear(dev_clear), .spoll_read(spoll_read),
        .srq_mask(srq_mask), .err_status(err_status), .srq(srq), .disp_msg(disp_msg),
        .cmd_valid(cmd_valid), .cmd_letter(cmd_letter), .cmd_option(cmd_option),
        .nrfd_hold(nrfd_hold), .eoi_enable(eoi_enable), .busy(busy));

    // Record applied commands and hold-off activity
    always @(posedge core_clk) begin
        if (cmd_valid === 1'b1) begin
            ncmd++;
            last_let = cmd_letter;
            last_opt = cmd_option;
        end
        if (nrfd_hold === 1'b1)
            nrfd_seen = 1'b1;
    end

    // Send one string and wait for the parser to settle
    task automatic run(input string s);
        ncmd = 0;
        nrfd_seen = 1'b0;
        bceh_ctrl_model_i.send(s);
        repeat (3) @(posedge core_clk);
        for (int k = 0; k < 60 && busy !== 1'b0; k++)
            @(posedge core_clk);
        `CHK(busy, 1'b0)
        @(posedge core_clk);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        rows = '{
            '{"F0X", 1, 3'h7, 3'h0, 2'h0, 1, "F", 8'h00},
            '{"F0M2P0R4X", 1, 3'h7, 3'h0, 2'h0, 4, "R", 8'h04},
            '{"R7 X", 1, 3'h7, 3'h0, 2'h0, 1, "R", 8'h07},
            '{"T01.0X", 1, 3'h7, 3'h0, 2'h0, 1, "T", 8'h01},
            '{"@0X", 1, 3'h1, 3'h1, 2'h1, 0, 8'h00, 8'h00},
            '{"$X", 1, 3'h6, 3'h1, 2'h1, 0, 8'h00, 8'h00},
            '{"D6X", 1, 3'h2, 3'h2, 2'h2, 0, 8'h00, 8'h00},
            '{"F0D6X", 1, 3'h5, 3'h2, 2'h2, 0, 8'h00, 8'h00},
            '{"D1X", 0, 3'h4, 3'h4, 2'h3, 0, 8'h00, 8'h00}};
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        `CHK({err_status, srq, disp_msg, cmd_valid, nrfd_hold, busy}, 9'h000)
        `CHK(eoi_enable, 1'b1)
        $display("test reset done");
        // Ordinary strings, one row each
        foreach (rows[i]) begin
            remote_mode <= rows[i].rem;
            srq_mask    <= rows[i].mask;
            run(rows[i].s);
            `CHK(err_status, rows[i].err)
            `CHK(srq, |(rows[i].err & rows[i].mask))
            `CHK(disp_msg, rows[i].disp)
            `CHK(ncmd, rows[i].ncmd)
            `CHK(nrfd_seen, rows[i].ncmd > 0)
            if (rows[i].ncmd > 0)
                `CHK({last_let, last_opt}, {rows[i].ltr, rows[i].opt})
            repeat (25) @(posedge core_clk);
            `CHK(disp_msg, DISP_NORMAL)
            spoll_read <= 1'b1;
            @(posedge core_clk);
            spoll_read <= 1'b0;
            @(posedge core_clk);
            `CHK({err_status, srq}, 4'h0)
            $display("test row %0d done", i);
        end
        // Error with mask off raises no service request
        remote_mode <= 1'b1;
        srq_mask    <= 3'h6;
        run("Q2X");
        `CHK({err_status, srq}, 4'h2)
        spoll_read <= 1'b1;
        @(posedge core_clk);
        spoll_read <= 1'b0;
        $display("test mask done");
        // Hold-off off, then restored by device clear
        run("K3X");
        `CHK({ncmd, eoi_enable}, {32'd1, 1'b0})
        run("F1X");
        `CHK({ncmd, nrfd_seen}, {32'd1, 1'b0})
        dev_clear <= 1'b1;
        @(posedge core_clk);
        dev_clear <= 1'b0;
        run("F1X");
        `CHK({nrfd_seen, eoi_enable}, 2'h3)
        // No command applied before terminator arrives
        ncmd = 0;
        bceh_ctrl_model_i.send("F1M2");
        repeat (6) @(posedge core_clk);
        `CHK(ncmd, 0)
        run("X");
        `CHK(ncmd, 2)
        $display("test holdoff done");
        // Error and serial-poll clear in one cycle: the error bit stays
        fork
            run("@X");
            begin
                @(posedge core_clk);
                spoll_read <= 1'b1;
                @(posedge core_clk);
                spoll_read <= 1'b0;
            end
        join
        `CHK(err_status, 3'h1)
        $display("test set beats clear done");
        // Reset after a run that turns EOI off: outputs cleared, no message, EOI back on
        run("K1X");
        `CHK(eoi_enable, 1'b0)
        sys_rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        `CHK({err_status, srq, disp_msg, cmd_valid, nrfd_hold, busy, eoi_enable}, 10'h001)
        run("F1X");
        `CHK({ncmd, nrfd_seen}, {32'd1, 1'b1})
        $display("test reset again done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
